// ==== hdl/reset_input_lock_consts.svh ====
// Register map, key codes and field positions of the reset input lock control
`ifndef RESET_INPUT_LOCK_CONSTS_SVH
`define RESET_INPUT_LOCK_CONSTS_SVH

// Register addresses
`define RSC_ADDR 12'hfde
`define KEY_ADDR 12'hfdf
`define FLAGS_ADDR 12'hfcc

// Key codes
`define KEY_DISABLE_CODE 8'hb2
`define KEY_FLAG_CLEAR_CODE 8'h71
`define KEY_AREA_VECTOR_CODE 8'h4d

// Field positions in the staged control, status and flags registers
`define BIT_DISABLE 0
`define BIT_AREA 1
`define BIT_VECTOR 2
`define BIT_FLAG_CLEAR 7

// Flag positions for the internal sources other than power-on
`define FLAG_POS_WATCHDOG 0
`define FLAG_POS_CLOCK_FAULT 1
`define FLAG_POS_VOLTAGE1 2
`define FLAG_POS_VOLTAGE2 3
`define FLAG_POS_TRIM 4
`define FLAG_POS_FLASH 6

// Reset value and internal source count
`define RESET_BYTE 8'h00
`define NUM_INT_SOURCES 6

`endif

// ==== hdl/reset_lock_pkg.sv ====
// Types shared by the reset input lock control modules
package reset_lock_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [11:0] addr_type;
  typedef logic [2:0] staged_type;
  typedef logic [6:0] flags_type;
endpackage

// ==== hdl/key_commit_if.sv ====
// Carrier between the register core and the key decoder
`timescale 1ns/1ps
interface key_commit_if;
  logic wr;
  reset_lock_pkg::addr_type addr;
  reset_lock_pkg::byte_type wdata;
  logic commit_disable;
  logic commit_area_vector;
  logic commit_flag_clear;

  modport decoder (
    input wr,
    input addr,
    input wdata,
    output commit_disable,
    output commit_area_vector,
    output commit_flag_clear
  );
  modport core (
    output wr,
    output addr,
    output wdata,
    input commit_disable,
    input commit_area_vector,
    input commit_flag_clear
  );
endinterface // key_commit_if

// ==== hdl/key_commit_decoder.sv ====
// Key register decoder producing one-cycle commit pulses
`timescale 1ns/1ps
`include "reset_input_lock_consts.svh"
module key_commit_decoder #(
  parameter reset_lock_pkg::byte_type AREA_VECTOR_CODE = `KEY_AREA_VECTOR_CODE
) (
  input wire logic clk,
  input wire logic rst,
  key_commit_if.decoder kc
);
  logic dis_ff, area_ff, clr_ff;
  logic nxt_dis, nxt_area, nxt_clr;
  logic key_wr;

  // Exact eight-bit match; any other code is dropped silently
  always_comb begin
    key_wr = kc.wr && (kc.addr == `KEY_ADDR);
    nxt_dis = key_wr && (kc.wdata == `KEY_DISABLE_CODE);
    nxt_area = key_wr && (kc.wdata == AREA_VECTOR_CODE);
    nxt_clr = key_wr && (kc.wdata == `KEY_FLAG_CLEAR_CODE);
  end

  // Pulses last exactly one cycle since strobes do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dis_ff <= 1'b0;
      area_ff <= 1'b0;
      clr_ff <= 1'b0;
    end else begin
      dis_ff <= nxt_dis;
      area_ff <= nxt_area;
      clr_ff <= nxt_clr;
    end
  end

  assign kc.commit_disable = dis_ff;
  assign kc.commit_area_vector = area_ff;
  assign kc.commit_flag_clear = clr_ff;
endmodule // key_commit_decoder

// ==== hdl/reset_input_lock_control.sv ====
// Reset merge and key-locked external reset disable control
//
// Overview of operation
// - System reset is raised by power-on reset, by the external input unless the disable bit is committed, or by any of the six internal sources.
// - Of the kinds of reset, only power-on reset clears the committed disable bit.
// - Staged control bits return to zero on every kind of reset.
// - The staged disable bit takes effect only when the key register receives 0xb2.
// - Key 0x71 commits the flag clear request, another code the other bits, others do nothing.
// - The status register at the key address shows the committed disable bit in bit 0.
// - Bits 7 to 3 of the staged control register read as zero.
// - Bits 7 to 3 of the status register read as zero.
// - A committed flag clear request clears the internal source reset flags.
`timescale 1ns/1ps
`include "reset_input_lock_consts.svh"
module reset_input_lock_control #(
  parameter reset_lock_pkg::byte_type AREA_VECTOR_CODE = `KEY_AREA_VECTOR_CODE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_reset_n,
  input wire logic [`NUM_INT_SOURCES-1:0] int_reset_src,
  input wire reset_lock_pkg::addr_type addr,
  input wire reset_lock_pkg::byte_type wdata,
  input wire logic wr,
  input wire logic rd,
  output reset_lock_pkg::byte_type rdata_ff,
  output logic system_reset_ff,
  output logic ext_reset_disable_committed_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Key decoder

  key_commit_if kc ();
  assign kc.wr = wr;
  assign kc.addr = addr;
  assign kc.wdata = wdata;

  key_commit_decoder #(
    .AREA_VECTOR_CODE(AREA_VECTOR_CODE)
  ) u_key (
    .clk(clk),
    .rst(rst),
    .kc(kc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset merge

  logic nxt_system_reset;

  // One flop of delay keeps the output glitch free
  always_comb begin
    nxt_system_reset = (!ext_reset_n && !ext_reset_disable_committed_ff) || (|int_reset_src);
  end

  // Power-on reset asserts system reset directly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      system_reset_ff <= 1'b1;
    end else begin
      system_reset_ff <= nxt_system_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staged and committed control bits

  reset_lock_pkg::staged_type staged_ff, nxt_staged;
  logic fclr_staged_ff, nxt_fclr_staged;
  logic area_committed_ff, nxt_area_committed;
  logic vector_committed_ff, nxt_vector_committed;
  logic nxt_disable_committed;

  always_comb begin
    nxt_staged = staged_ff;
    nxt_fclr_staged = fclr_staged_ff;
    if (wr && addr == `RSC_ADDR) begin
      nxt_staged = wdata[2:0];
    end
    if (wr && addr == `FLAGS_ADDR) begin
      nxt_fclr_staged = wdata[`BIT_FLAG_CLEAR];
    end
    // staged bits cleared by any reset
    if (system_reset_ff) begin
      nxt_staged = 3'h0;
      nxt_fclr_staged = 1'b0;
    end
    nxt_disable_committed = ext_reset_disable_committed_ff;
    nxt_area_committed = area_committed_ff;
    nxt_vector_committed = vector_committed_ff;
    if (kc.commit_disable) begin
      nxt_disable_committed = staged_ff[`BIT_DISABLE];
    end
    if (kc.commit_area_vector) begin
      nxt_area_committed = staged_ff[`BIT_AREA];
      nxt_vector_committed = staged_ff[`BIT_VECTOR];
    end
  end

  // committed bits see power-on reset only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      staged_ff <= 3'h0;
      fclr_staged_ff <= 1'b0;
      ext_reset_disable_committed_ff <= 1'b0;
      area_committed_ff <= 1'b0;
      vector_committed_ff <= 1'b0;
    end else begin
      staged_ff <= nxt_staged;
      fclr_staged_ff <= nxt_fclr_staged;
      ext_reset_disable_committed_ff <= nxt_disable_committed;
      area_committed_ff <= nxt_area_committed;
      vector_committed_ff <= nxt_vector_committed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal source reset flags

  reset_lock_pkg::flags_type flags_ff, nxt_flags, flag_set;

  // Per-source flag set, bit 5 has no source here
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_flag
      if (g == 5) begin : g_none
        assign flag_set[g] = 1'b0;
      end else begin : g_src
        assign flag_set[g] = int_reset_src[g < 5 ? g : 5];
      end
    end
  endgenerate

  // Set wins over a committed clear in the same cycle
  always_comb begin
    nxt_flags = flags_ff;
    if (kc.commit_flag_clear && fclr_staged_ff) begin
      nxt_flags = 7'h00;
    end
    nxt_flags = nxt_flags | flag_set;
  end

  // Flags survive the resets they record
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff <= 7'h00;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  reset_lock_pkg::byte_type nxt_rdata;

  // Key register is write-only, so its address returns status instead
  always_comb begin
    nxt_rdata = `RESET_BYTE;
    if (rd) begin
      unique case (addr)
        `RSC_ADDR: nxt_rdata = {5'h00, staged_ff};
        `KEY_ADDR: nxt_rdata = {5'h00, vector_committed_ff, area_committed_ff,
          ext_reset_disable_committed_ff};
        `FLAGS_ADDR: nxt_rdata = {1'b0, flags_ff};
        default: nxt_rdata = `RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= `RESET_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

endmodule // reset_input_lock_control

// ==== verification/reset_lock_properties.sv ====
// Port assertions of the reset input lock control
`timescale 1ns/1ps
`include "reset_input_lock_consts.svh"
module reset_lock_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_reset_n,
  input wire logic [5:0] int_reset_src,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata_ff,
  input wire logic system_reset_ff,
  input wire logic ext_reset_disable_committed_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Aliases; a key write is a whole byte
  wire dis = ext_reset_disable_committed_ff;
  wire kw = wr && addr == `KEY_ADDR;
  reset_merge_a: assert property (
    !$past(rst) |-> system_reset_ff == $past(!ext_reset_n && !dis || |int_reset_src))
    else $error("merge");
  ext_ignored_a: assert property (
    dis && !ext_reset_n && !int_reset_src |=> !system_reset_ff) else $error("ignore");
  key_commit_a: assert property (
    $changed(dis) |-> $past(kw && wdata == 8'hb2, 2)) else $error("commit");
  other_key_a: assert property (
    kw && wdata != 8'hb2 |-> ##2 $stable(dis)) else $error("other key");
  idle_read_a: assert property (
    !$past(rd) |-> rdata_ff == 8'h00) else $error("idle read");
  status_bit_a: assert property (
    $past(rd && addr == `KEY_ADDR) |-> rdata_ff[0] == $past(dis)) else $error("status");
  upper_zero_a: assert property (
    $past(rd && addr[11:1] == 11'h7ef) |-> rdata_ff[7:3] == 5'h00) else $error("upper");
  staged_clear_a: assert property (
    $fell(system_reset_ff) && !wr ##1 rd && addr == `RSC_ADDR |=> rdata_ff == 8'h00)
    else $error("staged");
endmodule // reset_lock_chk
bind reset_input_lock_control reset_lock_chk reset_lock_chk_i (.clk(clk), .rst(rst),
  .ext_reset_n(ext_reset_n), .int_reset_src(int_reset_src), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .system_reset_ff(system_reset_ff),
  .ext_reset_disable_committed_ff(ext_reset_disable_committed_ff));

// ==== verification/reset_source_model.sv ====
// Model of the reset pin and the internal reset sources
`timescale 1ns/1ps
module reset_source_model (
  input wire logic clk,
  output logic ext_reset_n,
  output logic [5:0] int_reset_src
);
  // Pin idles high, sources quiet
  initial ext_reset_n = 1'b1;
  initial int_reset_src = 6'h00;
  task automatic pulse(input logic e, input logic [5:0] s);
    @(posedge clk);
    ext_reset_n <= !e;
    int_reset_src <= s;
    @(posedge clk);
    ext_reset_n <= 1'b1;
    int_reset_src <= 6'h00;
  endtask
endmodule // reset_source_model

// ==== verification/reset_input_lock_control_bench.sv ====
// Self-checking bench of the reset input lock control
`timescale 1ns/1ps
`include "reset_input_lock_consts.svh"
module reset_input_lock_control_bench;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00, rdata_ff;
  logic sys_ff, dis_ff, ext_reset_n;
  logic [5:0] int_reset_src;
  int n_fail = 0, check_count = 0, m_dis = 0, m_flags = 0, k, v;
  // Free-running system clock
  always #5 clk = ~clk;
  reset_source_model reset_source_model_i (.clk(clk), .ext_reset_n(ext_reset_n),
    .int_reset_src(int_reset_src));
  reset_input_lock_control reset_input_lock_control_i (.clk(clk), .rst(rst),
    .ext_reset_n(ext_reset_n), .int_reset_src(int_reset_src), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .system_reset_ff(sys_ff),
    .ext_reset_disable_committed_ff(dis_ff));
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("%0d checks, %0d mismatches", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bus cycle: a write, or a read compared one cycle later
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 if (!w) check(rdata_ff, d);
  endtask
  // Bounded wait; staged bits are only writable once reset drops
  task automatic idle();
    int i;
    for (i = 0; i < 20 && sys_ff !== 1'b0; i++)
      @(posedge clk) #1;
    if (i == 20) begin
      n_fail++;
      results();
    end
  endtask
  task automatic hit(input logic e, input logic [5:0] s, input logic x);
    reset_source_model_i.pulse(e, s);
    #1 check(sys_ff, x);
    idle();
  endtask
  // Main sequence
  initial begin
    v = $urandom(18);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    idle();
    bus(1'b0, `RSC_ADDR, 8'h00);
    bus(1'b0, `KEY_ADDR, 8'h00);
    bus(1'b0, 12'h0a0 + 12'($urandom % 64), 8'h00);
    $display("t1 done");
    v = $urandom;
    // Staged disable forced to 1 so an early commit would show
    bus(1'b1, `RSC_ADDR, v[7:0] | 8'h01);
    bus(1'b0, `RSC_ADDR, (v[7:0] | 8'h01) & 8'h07);
    repeat (6) bus(1'b1, `KEY_ADDR, 8'($urandom % 64));
    bus(1'b0, `KEY_ADDR, 8'(m_dis));
    hit(1'b1, 6'h00, m_dis == 0);
    bus(1'b0, `RSC_ADDR, 8'h00);
    $display("t2 done");
    bus(1'b1, `RSC_ADDR, 8'h01);
    bus(1'b1, `KEY_ADDR, 8'hb2);
    m_dis = 1;
    bus(1'b0, `KEY_ADDR, 8'(m_dis));
    hit(1'b1, 6'h00, m_dis == 0);
    for (k = 0; k < 6; k++) begin
      hit(1'b0, 6'h01 << k, 1'b1);
      m_flags |= 1 << (k + (k == 5));
    end
    bus(1'b0, `KEY_ADDR, 8'(m_dis));
    bus(1'b0, `FLAGS_ADDR, 8'(m_flags));
    bus(1'b1, `FLAGS_ADDR, 8'h80);
    bus(1'b1, `KEY_ADDR, 8'h71);
    bus(1'b0, `FLAGS_ADDR, 8'h00);
    $display("t3 done");
    // Two edges of reset, so no assertion attempt starts inside it
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    m_dis = 0;
    idle();
    check(dis_ff, 8'(m_dis));
    bus(1'b1, `RSC_ADDR, 8'h06);
    bus(1'b1, `KEY_ADDR, `KEY_AREA_VECTOR_CODE);
    bus(1'b0, `KEY_ADDR, 8'h06);
    hit(1'b1, 6'h00, m_dis == 0);
    bus(1'b0, `KEY_ADDR, 8'h06);
    $display("t4 done");
    results();
  end
endmodule // reset_input_lock_control_bench
